//--- current_unbalance_protection.sv
// current unbalance protection: start and delayed trip with wishbone setup
//
// What this block does
// - unbalance flag when (max-min) as percent of max exceeds setting
// - sufficient-level flag only while max exceeds a tenth of rated
// - non-fault flag only while max stays below 1.5 times rated
// - start is all three flags gated by enable and blocking input
// - trip asserts after start condition persisted for the set delay
// - start-only setting, default false, suppresses trip but keeps start
// - start threshold 10 to 90 percent, step 1, default 50
// - trip delay 100 to 60000 ms, step 1 ms, default 1000
// - delay counted from onset of the faulty condition itself
// - blocking input suppresses both start and trip
// - general start output readable by software and logic
// - general trip output carries trip command downstream
// - event on every on and off transition of start and trip
// - operation off holds both outputs inactive
`timescale 1ns/1ps
`default_nettype none
`include "unbalance_map.svh"

module current_unbalance_protection #(
    parameter int unsigned CYCLES_PER_MS = `UNB_CYCLES_PER_MS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // phase magnitudes from the upstream estimator
    input wire unbalance_pkg::magnitude_type phase_a_magnitude_i,
    input wire unbalance_pkg::magnitude_type phase_b_magnitude_i,
    input wire unbalance_pkg::magnitude_type phase_c_magnitude_i,
    // blocking input from user logic
    input wire logic unbalance_block_in_i,
    // general start and trip
    output logic unbalance_start_out_o,
    output logic unbalance_trip_out_o,
    // on and off events
    output logic start_on_o,
    output logic start_off_o,
    output logic trip_on_o,
    output logic trip_off_o
);
    import unbalance_pkg::*;

    state_type s_q;
    state_type s_d;

    function automatic logic [15:0] max3(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [15:0] c);
        logic [15:0] m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    function automatic logic [15:0] min3(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [15:0] c);
        logic [15:0] m;
        m = (a < b) ? a : b;
        return (m < c) ? m : c;
    endfunction

    // out-of-range writes land on the nearest limit rather than being lost
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] wide(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    function automatic logic [31:0] pct_word(input logic [6:0] p);
        return {25'h0, p};
    endfunction

    // set on the plain threshold, hold down to 95 % of it so that noise
    // near the limit does not chatter the start
    function automatic logic unbal_eval(input logic held,
                                        input logic [31:0] diff,
                                        input logic [31:0] pct,
                                        input logic [31:0] mx);
        if (held) begin
            return (diff * `UNB_HYST_DIFF) >=
                   (pct * `UNB_HYST_PCT * mx);
        end
        return (diff * `UNB_PCT_SCALE) > (pct * mx);
    endfunction

    // every reset value in one place, so the register sees one write
    function automatic state_type reset_state();
        state_type r;
        r = '0;
        r.tstate = T_IDLE;
        r.operation = `UNB_OPERATION_RST;
        r.start_only = `UNB_START_ONLY_RST;
        r.pct = 7'(`UNB_PCT_RST);
        r.delay_ms = `UNB_DELAY_RST;
        r.rated = `UNB_RATED_RST;
        return r;
    endfunction

    logic [31:0] last_pre;
    assign last_pre = CYCLES_PER_MS - 32'h00000001;

    logic [15:0] cur_max;
    logic [15:0] cur_min;
    logic [31:0] diff_w;
    logic [31:0] max_w;
    logic [31:0] pct_w;
    logic [31:0] rated_w;
    logic cond;
    logic wr;
    logic req;
    logic [31:0] ctrl_rd;
    logic [31:0] status_rd;
    logic [31:0] wmerged;
    logic [15:0] ms_next;

    always_comb begin
        s_d = s_q;
        cur_max = max3(phase_a_magnitude_i, phase_b_magnitude_i,
                       phase_c_magnitude_i);
        cur_min = min3(phase_a_magnitude_i, phase_b_magnitude_i,
                       phase_c_magnitude_i);
        s_d.imax = cur_max;
        s_d.imin = cur_min;

        diff_w = wide(s_q.imax - s_q.imin);
        max_w = wide(s_q.imax);
        pct_w = pct_word(s_q.pct);
        rated_w = wide(s_q.rated);

        s_d.unbal = unbal_eval(s_q.unbal, diff_w, pct_w, max_w);
        s_d.suff = (max_w * `UNB_SUFF_MUL) > rated_w;
        s_d.nofault = (max_w * `UNB_FAULT_MUL_MAX) <
                      (rated_w * `UNB_FAULT_MUL_RATED);

        cond = s_q.operation && !unbalance_block_in_i && s_q.unbal &&
               s_q.suff && s_q.nofault;
        s_d.start = cond;

        // timer starts in the cycle the condition appears, not after start
        ms_next = s_q.ms + 16'h0001;
        case (s_q.tstate)
            T_IDLE: begin
                s_d.pre = 32'h00000000;
                s_d.ms = 16'h0000;
                if (cond) begin
                    s_d.tstate = T_TIMING;
                end
            end
            T_TIMING: begin
                if (!cond) begin
                    s_d.tstate = T_IDLE;
                end else if (s_q.pre >= last_pre) begin
                    s_d.pre = 32'h00000000;
                    s_d.ms = ms_next;
                    if (ms_next >= s_q.delay_ms) begin
                        s_d.tstate = T_TRIPPED;
                    end
                end else begin
                    s_d.pre = s_q.pre + 32'h00000001;
                end
            end
            T_TRIPPED: begin
                if (!cond) begin
                    s_d.tstate = T_IDLE;
                end
            end
            default: begin
                s_d.tstate = T_IDLE;
            end
        endcase
        s_d.trip = cond && (s_d.tstate == T_TRIPPED) &&
                   !s_q.start_only;

        s_d.start_on = s_d.start && !s_q.start;
        s_d.start_off = !s_d.start && s_q.start;
        s_d.trip_on = s_d.trip && !s_q.trip;
        s_d.trip_off = !s_d.trip && s_q.trip;
        if (s_d.start_on) begin
            s_d.start_count = s_q.start_count + 16'h0001;
        end
        if (s_d.trip_on) begin
            s_d.trip_count = s_q.trip_count + 16'h0001;
        end

        // bus: answer one cycle after the request, commit at the ack edge
        req = wb_cyc_i && wb_stb_i && !s_q.ack;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;
        s_d.ack = req;

        ctrl_rd = 32'h00000000;
        ctrl_rd[`UNB_CTRL_OPERATION] = s_q.operation;
        ctrl_rd[`UNB_CTRL_START_ONLY] = s_q.start_only;
        status_rd = 32'h00000000;
        status_rd[`UNB_ST_START] = s_q.start;
        status_rd[`UNB_ST_TRIP] = s_q.trip;
        status_rd[`UNB_ST_UNBAL] = s_q.unbal;
        status_rd[`UNB_ST_SUFF] = s_q.suff;
        status_rd[`UNB_ST_NOFAULT] = s_q.nofault;
        status_rd[`UNB_ST_TIMING] = (s_q.tstate == T_TIMING);

        s_d.rdat = 32'h00000000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `UNB_REG_CTRL: s_d.rdat = ctrl_rd;
                `UNB_REG_START_PCT: s_d.rdat = pct_word(s_q.pct);
                `UNB_REG_DELAY_MS: s_d.rdat = wide(s_q.delay_ms);
                `UNB_REG_RATED: s_d.rdat = wide(s_q.rated);
                `UNB_REG_STATUS: s_d.rdat = status_rd;
                `UNB_REG_MAXMIN: s_d.rdat = {s_q.imax, s_q.imin};
                `UNB_REG_EVCOUNT: s_d.rdat = {s_q.trip_count, s_q.start_count};
                default: s_d.rdat = 32'h00000000;
            endcase
        end

        wmerged = 32'h00000000;
        if (wr) begin
            case (wb_adr_i)
                `UNB_REG_CTRL: begin
                    wmerged = merge(ctrl_rd, wb_dat_i, wb_sel_i);
                    s_d.operation = wmerged[`UNB_CTRL_OPERATION];
                    s_d.start_only = wmerged[`UNB_CTRL_START_ONLY];
                end
                `UNB_REG_START_PCT: begin
                    wmerged = merge(pct_word(s_q.pct), wb_dat_i, wb_sel_i);
                    s_d.pct = 7'(clamp(wmerged[15:0], `UNB_PCT_MIN,
                                       `UNB_PCT_MAX));
                end
                `UNB_REG_DELAY_MS: begin
                    wmerged = merge(wide(s_q.delay_ms), wb_dat_i, wb_sel_i);
                    s_d.delay_ms = clamp(wmerged[15:0], `UNB_DELAY_MIN,
                                         `UNB_DELAY_MAX);
                end
                `UNB_REG_RATED: begin
                    wmerged = merge(wide(s_q.rated), wb_dat_i, wb_sel_i);
                    s_d.rated = wmerged[15:0];
                end
                default: begin
                    wmerged = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign unbalance_start_out_o = s_q.start;
    assign unbalance_trip_out_o = s_q.trip;
    assign start_on_o = s_q.start_on;
    assign start_off_o = s_q.start_off;
    assign trip_on_o = s_q.trip_on;
    assign trip_off_o = s_q.trip_off;

endmodule
`default_nettype wire

//--- current_unbalance_protection_test.sv
// self-checking bench for the current unbalance protection block
`timescale 1ns/1ps
`default_nettype none
module current_unbalance_protection_test;
    import unbalance_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, blk = 0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, rdat, rd;
    logic [47:0] lvl = '0;
    logic [47:0] tl [9] = '{48'h0190_0190_0010, 48'h01a0_01a0_0010,
        48'h1800_1800_0100, 48'h17ff_17ff_0100, 48'h1000_1000_0900,
        48'h1000_1000_0830, 48'h1000_1000_07ff, 48'h1000_1000_0830,
        48'h1000_1000_0900};
    logic te [9] = '{0, 1, 0, 1, 0, 0, 1, 1, 0};
    magnitude_type pa, pb, pc;
    logic st, tr, ack;
    int num_errors = 0, check_count = 0, cycles = 0, n;
    initial forever #2 clk_i = ~clk_i;
    magnitude_source src (.clk_i, .level_i(lvl), .phase_a_o(pa),
        .phase_b_o(pb), .phase_c_o(pc));
    current_unbalance_protection #(.CYCLES_PER_MS(4)) DUT (.clk_i, .rst_i,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phase_a_magnitude_i(pa), .phase_b_magnitude_i(pb),
        .phase_c_magnitude_i(pc), .unbalance_block_in_i(blk),
        .unbalance_start_out_o(st), .unbalance_trip_out_o(tr),
        .start_on_o(), .start_off_o(), .trip_on_o(), .trip_off_o());
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string s, input logic [31:0] e, got);
        check_count++;
        if (got !== e) begin
            $display("Error %s expected %h seen %h", s, e, got);
            num_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d[31:0]};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdchk(input string s, input logic [7:0] a, input int e);
        bus(0, a, 0);
        check(s, e[31:0], rd);
    endtask
    task automatic wait_st(input logic v);
        n = 0;
        while (st !== v && n < 12) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic t_regs;
        rdchk("ctrl", 8'h00, 0);
        rdchk("pct", 8'h04, 50);
        rdchk("delay", 8'h08, 1000);
        rdchk("unmapped", 8'h1c, 0);
        bus(1, 8'h04, 5);
        rdchk("pct low", 8'h04, 10);
        bus(1, 8'h04, 95);
        rdchk("pct high", 8'h04, 90);
        bus(1, 8'h04, 50);
        bus(1, 8'h08, 50);
        rdchk("delay low", 8'h08, 100);
    endtask
    task automatic t_trip;
        lvl <= 48'h1000_1000_0400;
        repeat (10) @(posedge clk_i);
        check("start off", 0, st);
        lvl <= 48'h1000_1000_1000;
        bus(1, 8'h00, 1);
        repeat (10) @(posedge clk_i);
        check("balanced", 0, st);
        lvl <= 48'h1000_1000_0400;
        wait_st(1);
        check("start", 1, st);
        n = 0;
        while (tr !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        check("trip delay", 400, n);
        rdchk("events", 8'h18, 32'h0001_0001);
        blk <= 1'b1;
        repeat (3) @(posedge clk_i);
        check("blocked", 0, {st, tr});
        blk <= 1'b0;
        wait_st(1);
        check("timer cleared", 0, tr);
    endtask
    task automatic t_levels;
        for (int i = 0; i < 9; i++) begin
            lvl <= tl[i];
            repeat (8) @(posedge clk_i);
            check("level case", te[i], st);
        end
    endtask
    task automatic t_only;
        bus(1, 8'h00, 3);
        lvl <= 48'h1000_1000_0400;
        repeat (440) @(posedge clk_i);
        check("start only", 2'b10, {st, tr});
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            final_report;
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_trip;
        t_levels;
        t_only;
        final_report;
    end
endmodule
`default_nettype wire

//--- magnitude_source.sv
// upstream estimator model handing per-phase magnitudes to the block
`timescale 1ns/1ps
`default_nettype none
module magnitude_source (
    // clock and requested levels
    input wire logic clk_i,
    input wire logic [47:0] level_i,
    // magnitudes, one register stage like a real estimator
    output var unbalance_pkg::magnitude_type phase_a_o,
    output var unbalance_pkg::magnitude_type phase_b_o,
    output var unbalance_pkg::magnitude_type phase_c_o
);
    import unbalance_pkg::*;
    always_ff @(posedge clk_i) begin
        phase_a_o <= level_i[47:32];
        phase_b_o <= level_i[31:16];
        phase_c_o <= level_i[15:0];
    end
endmodule
`default_nettype wire

//--- unbalance_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef UNBALANCE_MAP_SVH
`define UNBALANCE_MAP_SVH

// register byte offsets
`define UNB_REG_CTRL 8'h00
`define UNB_REG_START_PCT 8'h04
`define UNB_REG_DELAY_MS 8'h08
`define UNB_REG_RATED 8'h0c
`define UNB_REG_STATUS 8'h10
`define UNB_REG_MAXMIN 8'h14
`define UNB_REG_EVCOUNT 8'h18

// control register fields
`define UNB_CTRL_OPERATION 0
`define UNB_CTRL_START_ONLY 1

// status register fields
`define UNB_ST_START 0
`define UNB_ST_TRIP 1
`define UNB_ST_UNBAL 2
`define UNB_ST_SUFF 3
`define UNB_ST_NOFAULT 4
`define UNB_ST_TIMING 5

// settings: reset values and ranges
`define UNB_OPERATION_RST 1'b0
`define UNB_START_ONLY_RST 1'b0
`define UNB_PCT_RST 16'h0032
`define UNB_PCT_MIN 16'h000a
`define UNB_PCT_MAX 16'h005a
`define UNB_DELAY_RST 16'h03e8
`define UNB_DELAY_MIN 16'h0064
`define UNB_DELAY_MAX 16'hea60
`define UNB_RATED_RST 16'h1000

// level limits as ratios: max*10 > rated, max*2 < rated*3
`define UNB_SUFF_MUL 32'h0000000a
`define UNB_FAULT_MUL_MAX 32'h00000002
`define UNB_FAULT_MUL_RATED 32'h00000003

// unbalance comparison: diff*100 > pct*max; release below 95 %
`define UNB_PCT_SCALE 32'h00000064
`define UNB_HYST_DIFF 32'h000007d0
`define UNB_HYST_PCT 32'h00000013

// timing
`define UNB_MS_NS 1000000
`define UNB_CLK_PERIOD_NS 4
`define UNB_CYCLES_PER_MS (`UNB_MS_NS / `UNB_CLK_PERIOD_NS)

`endif

//--- unbalance_monitor.sv
// port checker for the current unbalance protection block
`timescale 1ns/1ps
`default_nettype none
module unbalance_monitor #(
    parameter int unsigned CYCLES_PER_MS = 4
) (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic unbalance_block_in_i,
    input wire logic unbalance_start_out_o,
    input wire logic unbalance_trip_out_o,
    input wire logic start_on_o,
    input wire logic start_off_o,
    input wire logic trip_on_o,
    input wire logic trip_off_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles of unbroken start, the floor for any trip
    logic [31:0] run_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || !unbalance_start_out_o) begin
            run_q <= '0;
        end else begin
            run_q <= run_q + 32'h1;
        end
    end
    ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("ack missing");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    start_event_a: assert property (start_on_o == $rose(unbalance_start_out_o)
        && start_off_o == $fell(unbalance_start_out_o))
        else $error("start event mismatch");
    trip_event_a: assert property (trip_on_o == $rose(unbalance_trip_out_o)
        && trip_off_o == $fell(unbalance_trip_out_o))
        else $error("trip event mismatch");
    block_holds_a: assert property (unbalance_block_in_i |=>
        !unbalance_start_out_o && !unbalance_trip_out_o)
        else $error("output while blocked");
    trip_needs_start_a: assert property (unbalance_trip_out_o |->
        unbalance_start_out_o) else $error("trip without start");
    trip_delay_min_a: assert property ($rose(unbalance_trip_out_o) |->
        run_q >= 100 * CYCLES_PER_MS - 2) else $error("trip too early");
    cover property ($rose(unbalance_start_out_o));
    cover property ($rose(unbalance_trip_out_o));
    cover property (unbalance_block_in_i && unbalance_start_out_o);
endmodule
bind current_unbalance_protection unbalance_monitor #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
) monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .unbalance_block_in_i, .unbalance_start_out_o, .unbalance_trip_out_o,
    .start_on_o, .start_off_o, .trip_on_o, .trip_off_o);
`default_nettype wire

//--- unbalance_pkg.sv
// types of the current unbalance protection block
`include "unbalance_map.svh"
package unbalance_pkg;

    typedef logic [15:0] magnitude_type;

    typedef enum logic [1:0] {
        T_IDLE,
        T_TIMING,
        T_TRIPPED
    } timer_state_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic operation;
        logic start_only;
        logic [6:0] pct;
        logic [15:0] delay_ms;
        logic [15:0] rated;
        logic [15:0] imax;
        logic [15:0] imin;
        logic unbal;
        logic suff;
        logic nofault;
        timer_state_type tstate;
        logic [31:0] pre;
        logic [15:0] ms;
        logic start;
        logic trip;
        logic start_on;
        logic start_off;
        logic trip_on;
        logic trip_off;
        logic [15:0] start_count;
        logic [15:0] trip_count;
    } state_type;

endpackage
